/* File: hw/hsc_pkg.sv */
// How it works
// R1: Boot firmware programs the slot capability fields of each live-insertion port in step order.
// R2: Bit 8 of the link capability word at config offset 0x5a reports a link wired to a slot.
// R3: Bit 0 of the slot capability word at config offset 0x6c reports a chassis button.
// R4: Bit 1 of the slot capability word reports a slot power switch.
// R5: Bit 3 of the slot capability word reports a chassis alert lamp.
// R6: Bit 4 of the slot capability word reports a chassis power lamp.
// R7: Bit 6 of the slot capability word reports that the slot supports live insertion.
// R8: Bit 17 of the slot capability word reports a slot latch.
// R9: While bit 18 of the slot capability word is clear, command completion notifies software.
// R10: Bits 31 to 19 of the slot capability word hold the physical slot number.
// R11: Firmware sets bit 4 of indirect port control register 0x10 to turn on power fault handling.
// R12: Capability bits hold what firmware wrote until reset and read back unchanged.
package hsc_pkg;

    // ========================================
    // Access widths
    localparam int CFG_ADDR_W = 12;
    localparam int IND_ADDR_W = 8;

    // ========================================
    // Configuration space offsets and the indirect port control index
    localparam logic [CFG_ADDR_W-1:0] CFG_LINK_CAP_OFS = 12'h05a;
    localparam logic [CFG_ADDR_W-1:0] CFG_LINK_CAP_DW = CFG_LINK_CAP_OFS & 12'hffc;
    localparam int LINK_CAP_LANE = 2;
    localparam logic [CFG_ADDR_W-1:0] CFG_SLOT_CAP_OFS = 12'h06c;
    localparam logic [IND_ADDR_W-1:0] IND_PORT_CNTL_IDX = 8'h10;

    // ========================================
    // Field positions
    localparam int LINK_SLOT_IMPL_BIT = 8;
    localparam int SLOT_BUTTON_BIT = 0;
    localparam int SLOT_POWER_SWITCH_BIT = 1;
    localparam int SLOT_ALERT_LAMP_BIT = 3;
    localparam int SLOT_POWER_LAMP_BIT = 4;
    localparam int SLOT_LIVE_INSERT_BIT = 6;
    localparam int SLOT_LATCH_BIT = 17;
    localparam int SLOT_NO_CMD_DONE_BIT = 18;
    localparam int SLOT_NUM_LSB = 19;
    localparam int SLOT_NUM_W = 13;
    localparam int PORT_PWR_FAULT_BIT = 4;

    // ========================================
    // Reset values
    localparam logic [15:0] LINK_CAP_RESET = 16'h0000;
    localparam logic [31:0] SLOT_CAP_RESET = 32'h0000_0000;
    localparam logic [31:0] PORT_CNTL_RESET = 32'h0000_0000;

    // ========================================
    // Request carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [CFG_ADDR_W-1:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wdata;
    } hsc_cfg_req_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [IND_ADDR_W-1:0] index;
        logic [31:0] wdata;
    } hsc_ind_req_s;

endpackage

/* File: hw/hsc_be_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_be_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH/8-1:0] byteEn,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] q
);
    localparam int LANES = WIDTH / 8;

    logic [7:0] lane_r [LANES];

    // ========================================
    // One flop group per byte lane
    genvar i;
    generate
        for (i = 0; i < LANES; i++)
        begin : g_lane
            always_ff @(posedge clk or negedge rstN)
            begin
                if (!rstN)
                    lane_r[i] <= RESET[8*i +: 8];
                else if (byteEn[i])
                    lane_r[i] <= wdata[8*i +: 8]; // [R12]
            end
            assign q[8*i +: 8] = lane_r[i];
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hw/hsc_slot_caps.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_slot_caps (
    input wire logic core_clk,
    input wire logic resetn,
    input wire hsc_pkg::hsc_cfg_req_s cfgReq,
    output logic [31:0] cfgRdata,
    output logic cfgRdValid,
    input wire hsc_pkg::hsc_ind_req_s indReq,
    output logic [31:0] indRdata,
    output logic indRdValid,
    input wire logic hpCmdDone,
    output logic cmdDoneNotify,
    output logic slotImplemented,
    output logic chassisButtonFitted,
    output logic slotPowerSwitchFitted,
    output logic chassisAlertLampFitted,
    output logic chassisPowerLampFitted,
    output logic slotSupportsLiveInsertion,
    output logic slotLatchFitted,
    output logic cmdDoneNotifyOn,
    output logic [hsc_pkg::SLOT_NUM_W-1:0] physicalSlotNum,
    output logic powerFaultHandlingOn
);
    // ========================================
    // Reset release
    logic rstMeta_r;
    logic rstSyncN;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta_r <= 1'b0;
            rstSyncN <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSyncN <= rstMeta_r;
        end
    end

    // ========================================
    // Address decode
    logic hitLink;
    logic hitSlot;
    logic hitPort;
    logic [1:0] linkBe;
    logic [3:0] slotBe;
    logic [3:0] portBe;
    logic [15:0] linkCap;
    logic [31:0] slotCap;
    logic [31:0] portCntl;

    assign hitLink = cfgReq.addr[hsc_pkg::CFG_ADDR_W-1:2] ==
                     hsc_pkg::CFG_LINK_CAP_DW[hsc_pkg::CFG_ADDR_W-1:2];
    assign hitSlot = cfgReq.addr[hsc_pkg::CFG_ADDR_W-1:2] ==
                     hsc_pkg::CFG_SLOT_CAP_OFS[hsc_pkg::CFG_ADDR_W-1:2];
    assign hitPort = indReq.index == hsc_pkg::IND_PORT_CNTL_IDX;

    // The link word shares its dword with registers outside this block
    assign linkBe = cfgReq.byteEn[hsc_pkg::LINK_CAP_LANE +: 2] & {2{cfgReq.wr & hitLink}}; // [R2]
    assign slotBe = cfgReq.byteEn & {4{cfgReq.wr & hitSlot}};
    // Indirect space writes whole words only
    assign portBe = {4{indReq.wr & hitPort}}; // [R11]

    // ========================================
    // Storage
    hsc_be_reg #(.WIDTH(16), .RESET(hsc_pkg::LINK_CAP_RESET)) u_link (
        .clk(core_clk),
        .rstN(rstSyncN),
        .byteEn(linkBe),
        .wdata(cfgReq.wdata[8*hsc_pkg::LINK_CAP_LANE +: 16]),
        .q(linkCap)
    );

    hsc_be_reg #(.WIDTH(32), .RESET(hsc_pkg::SLOT_CAP_RESET)) u_slot (
        .clk(core_clk),
        .rstN(rstSyncN),
        .byteEn(slotBe),
        .wdata(cfgReq.wdata),
        .q(slotCap)
    );

    hsc_be_reg #(.WIDTH(32), .RESET(hsc_pkg::PORT_CNTL_RESET)) u_port (
        .clk(core_clk),
        .rstN(rstSyncN),
        .byteEn(portBe),
        .wdata(indReq.wdata),
        .q(portCntl)
    );

    // ========================================
    // Capability outputs; all but the notification enable below come straight off the storage flops
    assign slotImplemented = linkCap[hsc_pkg::LINK_SLOT_IMPL_BIT]; // [R2]
    assign chassisButtonFitted = slotCap[hsc_pkg::SLOT_BUTTON_BIT]; // [R3]
    assign slotPowerSwitchFitted = slotCap[hsc_pkg::SLOT_POWER_SWITCH_BIT]; // [R4]
    assign chassisAlertLampFitted = slotCap[hsc_pkg::SLOT_ALERT_LAMP_BIT]; // [R5]
    assign chassisPowerLampFitted = slotCap[hsc_pkg::SLOT_POWER_LAMP_BIT]; // [R6]
    assign slotSupportsLiveInsertion = slotCap[hsc_pkg::SLOT_LIVE_INSERT_BIT]; // [R7]
    assign slotLatchFitted = slotCap[hsc_pkg::SLOT_LATCH_BIT]; // [R8]
    assign physicalSlotNum = slotCap[hsc_pkg::SLOT_NUM_LSB +: hsc_pkg::SLOT_NUM_W]; // [R10]
    assign powerFaultHandlingOn = portCntl[hsc_pkg::PORT_PWR_FAULT_BIT]; // [R11]

    // Reset leaves bit 18 clear, so notification is on until firmware opts out
    logic cmdDoneNotifyOn_r;
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            cmdDoneNotifyOn_r <= 1'b1;
        else
            cmdDoneNotifyOn_r <= ~slotCap[hsc_pkg::SLOT_NO_CMD_DONE_BIT]; // [R9]
    end
    assign cmdDoneNotifyOn = cmdDoneNotifyOn_r;

    // ========================================
    // Command completion event
    logic cmdDoneNotify_r;
    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            cmdDoneNotify_r <= 1'b0;
        else
            cmdDoneNotify_r <= hpCmdDone & ~slotCap[hsc_pkg::SLOT_NO_CMD_DONE_BIT]; // [R9]
    end
    assign cmdDoneNotify = cmdDoneNotify_r;

    // ========================================
    // Read back
    logic [31:0] cfgRdNxt;
    logic [31:0] cfgRdata_r;
    logic cfgRdValid_r;
    logic [31:0] indRdata_r;
    logic indRdValid_r;

    always_comb
    begin
        cfgRdNxt = 32'h0000_0000;
        if (hitLink)
            cfgRdNxt[8*hsc_pkg::LINK_CAP_LANE +: 16] = linkCap; // [R12]
        else if (hitSlot)
            cfgRdNxt = slotCap; // [R12]
    end

    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            cfgRdata_r <= 32'h0000_0000;
            cfgRdValid_r <= 1'b0;
        end
        else
        begin
            cfgRdValid_r <= cfgReq.rd;
            if (cfgReq.rd)
                cfgRdata_r <= cfgRdNxt;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            indRdata_r <= 32'h0000_0000;
            indRdValid_r <= 1'b0;
        end
        else
        begin
            indRdValid_r <= indReq.rd;
            if (indReq.rd)
                indRdata_r <= hitPort ? portCntl : 32'h0000_0000;
        end
    end

    assign cfgRdata = cfgRdata_r;
    assign cfgRdValid = cfgRdValid_r;
    assign indRdata = indRdata_r;
    assign indRdValid = indRdValid_r;

    // ========================================
    // Checks
    a_slot_impl_write: assert property ( // [R2]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitLink && cfgReq.byteEn[3]) |=> slotImplemented == $past(cfgReq.wdata[24]))
        else $error("slot implemented flag did not take the written value");

    a_button_write: assert property ( // [R3]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitSlot && cfgReq.byteEn[0]) |=>
            chassisButtonFitted == $past(cfgReq.wdata[0]))
        else $error("chassis button flag did not take the written value");

    a_switch_write: assert property ( // [R4]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitSlot && cfgReq.byteEn[0]) |=>
            slotPowerSwitchFitted == $past(cfgReq.wdata[1]))
        else $error("power switch flag did not take the written value");

    a_lamps_write: assert property ( // [R5] [R6]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitSlot && cfgReq.byteEn[0]) |=>
            {chassisPowerLampFitted, chassisAlertLampFitted} == $past(cfgReq.wdata[4:3]))
        else $error("lamp flags did not take the written value");

    a_live_insert: assert property ( // [R7]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitSlot && cfgReq.byteEn[0]) |=>
            slotSupportsLiveInsertion == $past(cfgReq.wdata[6]))
        else $error("live insertion flag did not take the written value");

    a_latch_write: assert property ( // [R8]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitSlot && cfgReq.byteEn[2]) |=> slotLatchFitted == $past(cfgReq.wdata[17]))
        else $error("latch flag did not take the written value");

    a_cmd_done_notify: assert property ( // [R9]
        @(posedge core_clk) disable iff (!rstSyncN)
        (hpCmdDone && !slotCap[18]) |=> cmdDoneNotify)
        else $error("completion not notified while notification is on");

    a_cmd_done_quiet: assert property ( // [R9]
        @(posedge core_clk) disable iff (!rstSyncN)
        (slotCap[18] && $stable(slotCap)) |=> !cmdDoneNotify && !cmdDoneNotifyOn)
        else $error("notification seen while it is switched off");

    a_slot_number: assert property ( // [R10]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.wr && hitSlot && (&cfgReq.byteEn[3:2])) |=>
            physicalSlotNum == $past(cfgReq.wdata[31:19]))
        else $error("slot number did not take the written value");

    a_power_fault: assert property ( // [R11]
        @(posedge core_clk) disable iff (!rstSyncN)
        (indReq.wr && hitPort) |=> powerFaultHandlingOn == $past(indReq.wdata[4]))
        else $error("power fault enable did not take the written value");

    a_caps_hold: assert property ( // [R12]
        @(posedge core_clk) disable iff (!rstSyncN)
        !(cfgReq.wr && hitSlot) |=> slotCap == $past(slotCap))
        else $error("slot capability changed without a write");

    a_slot_readback: assert property ( // [R12]
        @(posedge core_clk) disable iff (!rstSyncN)
        (cfgReq.rd && hitSlot) |=> cfgRdValid && cfgRdata == $past(slotCap))
        else $error("slot capability read back differs from stored value");
endmodule
`default_nettype wire

/* File: verif/hsc_slot_caps_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_slot_caps_tb;
    // ========================================
    // Signals
    logic core_clk;
    logic resetn;
    hsc_pkg::hsc_cfg_req_s cfgReq;
    hsc_pkg::hsc_ind_req_s indReq;
    logic hpCmdDone;
    logic [31:0] cfgRdata;
    logic cfgRdValid;
    logic [31:0] indRdata;
    logic indRdValid;
    logic cmdDoneNotify;
    logic slotImplemented;
    logic [6:0] capBits;
    logic [12:0] physicalSlotNum;
    logic powerFaultHandlingOn;
    int failures;
    int n_compared;
    int cycles;
    logic [31:0] seed;
    logic [31:0] slotM;
    logic [31:0] linkM;
    logic [31:0] portM;
    logic [31:0] d;
    logic [7:0] idx;

    hsc_slot_caps DUT (
        .core_clk(core_clk),
        .resetn(resetn),
        .cfgReq(cfgReq),
        .cfgRdata(cfgRdata),
        .cfgRdValid(cfgRdValid),
        .indReq(indReq),
        .indRdata(indRdata),
        .indRdValid(indRdValid),
        .hpCmdDone(hpCmdDone),
        .cmdDoneNotify(cmdDoneNotify),
        .slotImplemented(slotImplemented),
        .chassisButtonFitted(capBits[0]),
        .slotPowerSwitchFitted(capBits[1]),
        .chassisAlertLampFitted(capBits[2]),
        .chassisPowerLampFitted(capBits[3]),
        .slotSupportsLiveInsertion(capBits[4]),
        .slotLatchFitted(capBits[5]),
        .cmdDoneNotifyOn(capBits[6]),
        .physicalSlotNum(physicalSlotNum),
        .powerFaultHandlingOn(powerFaultHandlingOn)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            if (be[i])
                o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read data is checked in the cycle its one-cycle valid pulse stands
    task automatic cfgAcc(input logic w, input logic r, input logic [11:0] a,
                          input logic [3:0] be, input logic [31:0] dat);
        @(posedge core_clk);
        #1;
        cfgReq = '{wr: w, rd: r, addr: a, byteEn: be, wdata: dat};
        @(posedge core_clk);
        #1;
        cfgReq = '0;
    endtask

    task automatic indAcc(input logic w, input logic r, input logic [7:0] i,
                          input logic [31:0] dat);
        @(posedge core_clk);
        #1;
        indReq = '{wr: w, rd: r, index: i, wdata: dat};
        @(posedge core_clk);
        #1;
        indReq = '0;
    endtask

    // Waits one cycle first: the notification-enable output lags the stored bit
    task automatic checkOuts();
        @(posedge core_clk);
        #1;
        check("button", capBits[0], slotM[0]);
        check("powerSwitch", capBits[1], slotM[1]);
        check("alertLamp", capBits[2], slotM[3]);
        check("powerLamp", capBits[3], slotM[4]);
        check("liveInsert", capBits[4], slotM[6]);
        check("latch", capBits[5], slotM[17]);
        check("notifyOn", capBits[6], !slotM[18]);
        check("slotNum", physicalSlotNum, slotM[31:19]);
        check("slotImplemented", slotImplemented, linkM[24]);
        check("powerFault", powerFaultHandlingOn, portM[4]);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            end_sim();
        end
    end

    // ========================================
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        cfgReq = '0;
        indReq = '0;
        hpCmdDone = 1'b0;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        seed = 32'hecb1b2ac;
        slotM = '0;
        linkM = '0;
        portM = '0;
        repeat (16) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check("notifyOnAtReset", capBits[6], 1'b1);
        checkOuts();
        for (int n = 0; n < 24; n++)
        begin
            seed = lfsr(seed);
            d = (n == 0) ? 32'hffffffff : (n == 1) ? 32'h0 : seed;
            seed = lfsr(seed);
            slotM = merge(slotM, d, (n < 4) ? 4'hf : seed[3:0]);
            cfgAcc(1'b1, 1'b0, {10'h01b, seed[5:4]}, (n < 4) ? 4'hf : seed[3:0], d);
            linkM = merge(linkM, ~d, seed[7:6] == 2'b00 ? 4'hc : seed[11:8] & 4'hc);
            cfgAcc(1'b1, 1'b0, 12'h05a, seed[7:6] == 2'b00 ? 4'hc : seed[11:8], ~d);
            idx = seed[12] ? 8'h10 : seed[23:16];
            if (idx == 8'h10)
                portM = d ^ seed;
            indAcc(1'b1, 1'b0, idx, d ^ seed);
            checkOuts();
            cfgAcc(1'b0, 1'b1, 12'h06c, 4'h0, 32'h0);
            check("cfgRdValid", cfgRdValid, 1'b1);
            check("slotRead", cfgRdata, slotM);
            cfgAcc(1'b0, 1'b1, 12'h058, 4'h0, 32'h0);
            check("linkRead", cfgRdata, linkM);
            indAcc(1'b0, 1'b1, seed[13] ? 8'h10 : 8'h11, 32'h0);
            check("indRdValid", indRdValid, 1'b1);
            check("indRead", indRdata, seed[13] ? portM : 32'h0);
            @(posedge core_clk);
            #1;
            hpCmdDone = 1'b1;
            @(posedge core_clk);
            #1;
            hpCmdDone = 1'b0;
            check("cmdDoneNotify", cmdDoneNotify, !slotM[18]);
            @(posedge core_clk);
            #1;
            check("cmdDoneNotifyEnd", cmdDoneNotify, 1'b0);
        end
        // Unmapped dword ignores writes and reads zero
        cfgAcc(1'b1, 1'b0, 12'h100, 4'hf, 32'hffffffff);
        cfgAcc(1'b0, 1'b1, 12'h100, 4'h0, 32'h0);
        check("unmappedRead", cfgRdata, 32'h0);
        // Write and read in one cycle: the read sees the old word
        cfgAcc(1'b1, 1'b1, 12'h06c, 4'hf, ~slotM);
        check("sameCycleRead", cfgRdata, slotM);
        slotM = ~slotM;
        checkOuts();
        // Reset in mid-run brings every capability back to its reset value
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        slotM = '0;
        linkM = '0;
        portM = '0;
        repeat (3) @(posedge core_clk);
        #1;
        check("notifyOnAfterReset", capBits[6], 1'b1);
        checkOuts();
        cfgAcc(1'b0, 1'b1, 12'h06c, 4'h0, 32'h0);
        check("slotReadAfterReset", cfgRdata, 32'h0);
        indAcc(1'b0, 1'b1, 8'h10, 32'h0);
        check("indReadAfterReset", indRdata, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
